// ---- rtl/auto_reload_timer_four.v ----
// Auto-reload timer four with baud generator, compare and edge trigger modes
// Summary of operation
// - Count byte writes load reload, high read live, low read from snapshot
// - Overflow after 0xFFFF sets flag, reloads counter
// - Stopped: count write updates counter and reload
// - Running: count write changes reload only
// - Timer mode overflow raises enabled interrupt
// - Clock select one uses pin, zero system
// - Compare mode overflow toggles pin, sets flag
// - Baud mode overflow reloads and raises interrupt
// - Baud rate is prescaled clock/16/(65536-reload)
// - Baud compare outputs half baud square wave
// - Edge modes always count system clock
// - Edge modes idle until valid pin edge
// - Edge mode overflow flags, reloads, stops, waits
// - No retrigger: edges while counting ignored
// - Retrigger: edge reloads counter, no interrupt
// - Setting run enable keeps counter value
// - Interrupt enable bit gates timer interrupt
// - Mode codes: timer, baud, rising, falling
// - Prescale codes divide by 1, 8, 64, 256
// - Hardware sets overflow flag, software clears zero
// - Compare bit: compare in 0/1, retrigger 2/3
`timescale 1ns/100ps
`default_nettype none
`include "timer_four_defines.vh"
module auto_reload_timer_four #(
  parameter PRESCALE_WIDTH = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire timer_io_pin_in,
  output reg timer_io_pin_out,
  output wire timer_io_pin_oe,
  output wire timer_irq,
  output reg serial_port_one_baud_tick
);
  reg overflow_flag;
  reg compare_retrigger_enable;
  reg [1:0] prescale_select;
  reg [1:0] mode_select;
  reg run_enable;
  reg clock_source_select;
  reg timer_interrupt_enable;
  reg [15:0] counter;
  reg [15:0] reload;
  reg [7:0] high_latch;
  reg [7:0] low_read_latch;
  reg [PRESCALE_WIDTH-1:0] prescale_count;
  reg [3:0] baud_div;
  reg armed;
  reg [15:0] next_counter;
  reg next_armed;
  reg pre_source;
  reg pre_done;
  reg overflow;
  reg retrigger_load;
  wire pin_rise;
  wire pin_fall;
  wire edge_mode;
  wire trigger_edge;
  wire write_high;
  wire write_low;
  wire [15:0] written_word;

  pin_edge_sync edge_unit (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(timer_io_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign edge_mode = mode_select[1];
  assign trigger_edge = (mode_select == `MODE_RISE) ? pin_rise : pin_fall;
  assign write_high = reg_write && (reg_addr == `ADDR_COUNT_HIGH);
  assign write_low = reg_write && (reg_addr == `ADDR_COUNT_LOW);
  // High byte is held until the low byte completes the word
  assign written_word = {high_latch, reg_wdata};
  // Pin is driven only while the compare function is in use
  assign timer_io_pin_oe = compare_retrigger_enable && !edge_mode;
  assign timer_irq = overflow_flag && timer_interrupt_enable;

  // Source of each prescaler step
  always @* begin
    if (edge_mode) begin
      pre_source = 1'b1;
    end else if (clock_source_select) begin
      pre_source = pin_rise;
    end else begin
      pre_source = 1'b1;
    end
  end

  // Prescaler terminal count for 1, 8, 64 and 256
  always @* begin
    case (prescale_select)
      2'h0: pre_done = 1'b1;
      2'h1: pre_done = (prescale_count[2:0] == 3'h7);
      2'h2: pre_done = (prescale_count[5:0] == 6'h3F);
      2'h3: pre_done = (prescale_count[7:0] == 8'hFF);
      default: pre_done = 1'b1;
    endcase
  end

  // Counter next-state logic
  always @* begin
    next_counter = counter;
    next_armed = armed;
    overflow = 1'b0;
    retrigger_load = 1'b0;
    if (run_enable) begin
      if (edge_mode && !armed) begin
        if (trigger_edge) begin
          next_armed = 1'b1;
        end
      end else begin
        if (edge_mode && trigger_edge && compare_retrigger_enable) begin
          retrigger_load = 1'b1;
          next_counter = reload;
        end else if (pre_source && pre_done) begin
          if (counter == `COUNT_MAX) begin
            overflow = 1'b1;
            next_counter = reload;
            if (edge_mode) begin
              next_armed = 1'b0;
            end
          end else begin
            next_counter = counter + 16'h0001;
          end
        end
        // Without retrigger, edges while counting simply fall through
      end
    end else begin
      next_armed = 1'b0;
    end
    if (write_low && !run_enable) begin
      next_counter = written_word;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      prescale_count <= {PRESCALE_WIDTH{1'b0}};
    end else if (!run_enable || retrigger_load || (edge_mode && !armed)) begin
      prescale_count <= {PRESCALE_WIDTH{1'b0}};
    end else if (pre_source) begin
      if (pre_done) begin
        prescale_count <= {PRESCALE_WIDTH{1'b0}};
      end else begin
        prescale_count <= prescale_count + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Counter, reload and byte latches
  always @(posedge sys_clk) begin
    if (rst) begin
      counter <= `RESET_WORD;
      reload <= `RESET_WORD;
      high_latch <= `RESET_BYTE;
      armed <= 1'b0;
    end else begin
      counter <= next_counter;
      armed <= next_armed;
      if (write_high) begin
        high_latch <= reg_wdata;
      end
      if (write_low) begin
        reload <= written_word;
      end
    end
  end

  // Control register and overflow flag
  always @(posedge sys_clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      compare_retrigger_enable <= 1'b0;
      prescale_select <= 2'h0;
      mode_select <= `MODE_TIMER;
      run_enable <= 1'b0;
      clock_source_select <= 1'b0;
      timer_interrupt_enable <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `ADDR_CONTROL) begin
        compare_retrigger_enable <= reg_wdata[`CTL_COMPARE];
        prescale_select <= reg_wdata[`CTL_PS_HI:`CTL_PS_LO];
        mode_select <= reg_wdata[`CTL_MODE_HI:`CTL_MODE_LO];
        run_enable <= reg_wdata[`CTL_RUN];
        clock_source_select <= reg_wdata[`CTL_CLKSRC];
      end
      if (reg_write && reg_addr == `ADDR_INT_ENABLE) begin
        timer_interrupt_enable <= reg_wdata[`IE_TIMER_BIT];
      end
      // A hardware set in the same cycle beats a software clear
      if (overflow) begin
        overflow_flag <= 1'b1;
      end else if (reg_write && reg_addr == `ADDR_CONTROL && !reg_wdata[`CTL_OVERFLOW]) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // Compare toggle, half-baud square wave and baud tick
  always @(posedge sys_clk) begin
    if (rst) begin
      timer_io_pin_out <= 1'b0;
      baud_div <= 4'h0;
      serial_port_one_baud_tick <= 1'b0;
    end else begin
      serial_port_one_baud_tick <= 1'b0;
      if (overflow && mode_select == `MODE_TIMER && compare_retrigger_enable) begin
        timer_io_pin_out <= ~timer_io_pin_out;
      end
      if (overflow && mode_select == `MODE_BAUD) begin
        // Sixteen overflows make one bit time
        if (baud_div == `BAUD_OVERSAMPLE) begin
          baud_div <= 4'h0;
          serial_port_one_baud_tick <= 1'b1;
          if (compare_retrigger_enable) begin
            timer_io_pin_out <= ~timer_io_pin_out;
          end
        end else begin
          baud_div <= baud_div + 4'h1;
        end
      end
    end
  end

  // Reads: low byte comes from a snapshot taken when the high byte is read
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= `RESET_BYTE;
      low_read_latch <= `RESET_BYTE;
    end else begin
      reg_rdata <= `RESET_BYTE;
      if (reg_read) begin
        case (reg_addr)
          `ADDR_CONTROL: reg_rdata <= {overflow_flag, compare_retrigger_enable, prescale_select,
                                       mode_select, run_enable, clock_source_select};
          `ADDR_COUNT_HIGH: begin
            reg_rdata <= counter[15:8];
            low_read_latch <= counter[7:0];
          end
          `ADDR_COUNT_LOW: reg_rdata <= low_read_latch;
          `ADDR_INT_ENABLE: reg_rdata <= {7'h00, timer_interrupt_enable};
          `ADDR_BAUD_STATUS: reg_rdata <= {armed, timer_io_pin_out, 2'h0, baud_div};
          default: reg_rdata <= `RESET_BYTE;
        endcase
      end
    end
  end
endmodule // auto_reload_timer_four
`default_nettype wire

// ---- rtl/timer_four_defines.vh ----
// Constants for the auto-reload timer four block
`ifndef TIMER_FOUR_DEFINES_VH
`define TIMER_FOUR_DEFINES_VH
`define ADDR_CONTROL 3'h0
`define ADDR_COUNT_HIGH 3'h1
`define ADDR_COUNT_LOW 3'h2
`define ADDR_INT_ENABLE 3'h3
`define ADDR_BAUD_STATUS 3'h4
`define CTL_OVERFLOW 7
`define CTL_COMPARE 6
`define CTL_PS_HI 5
`define CTL_PS_LO 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 2
`define CTL_RUN 1
`define CTL_CLKSRC 0
`define IE_TIMER_BIT 0
`define MODE_TIMER 2'h0
`define MODE_BAUD 2'h1
`define MODE_RISE 2'h2
`define MODE_FALL 2'h3
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define COUNT_MAX 16'hFFFF
`define BAUD_OVERSAMPLE 4'hF
`endif

// ---- rtl/pin_edge_sync.v ----
// Two-stage synchroniser and edge detector for the timer pin
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
  input wire sys_clk,
  input wire rst,
  input wire pin_in,
  output wire rise,
  output wire fall
);
  reg stage_one;
  reg stage_two;
  reg stage_last;
  always @(posedge sys_clk) begin
    if (rst) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_last <= 1'b0;
    end else begin
      stage_one <= pin_in;
      stage_two <= stage_one;
      stage_last <= stage_two;
    end
  end
  // Edges are seen only on the second stage, never on the first
  assign rise = stage_two & ~stage_last;
  assign fall = ~stage_two & stage_last;
endmodule // pin_edge_sync
`default_nettype wire

// ---- tb/timer_four_properties.sv ----
// Port-level assertions for the auto-reload timer four
`timescale 1ns/100ps
`default_nettype none
`include "timer_four_defines.vh"
module timer_four_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_io_pin_in,
  input wire logic timer_io_pin_out,
  input wire logic timer_io_pin_oe,
  input wire logic timer_irq,
  input wire logic serial_port_one_baud_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire ctl_wr = reg_write && reg_addr == `ADDR_CONTROL;
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_read && reg_addr > `ADDR_BAUD_STATUS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_pin: assert property (reg_read && reg_addr == `ADDR_BAUD_STATUS
    |=> reg_rdata[6] == $past(timer_io_pin_out)) else $error("status pin bit wrong");
  a_oe_decode: assert property (ctl_wr |=> timer_io_pin_oe == ($past(reg_wdata[6]) && !$past(reg_wdata[3])))
    else $error("pin enable decode wrong");
  a_oe_held: assert property (!ctl_wr |=> $stable(timer_io_pin_oe))
    else $error("pin enable moved");
  a_irq_masked: assert property (reg_write && reg_addr == `ADDR_INT_ENABLE && !reg_wdata[0] |=> !timer_irq)
    else $error("interrupt not masked");
  a_tick_gap: assert property (serial_port_one_baud_tick |=> !serial_port_one_baud_tick [*8])
    else $error("baud ticks too close");
  a_pin_needs_oe: assert property ($changed(timer_io_pin_out) |-> $past(timer_io_pin_oe))
    else $error("pin toggled undriven");
endmodule // timer_four_properties
bind auto_reload_timer_four timer_four_properties chk_u (.*);
`default_nettype wire

// ---- tb/pin_source.sv ----
// External source on the timer pin
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input wire logic sys_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Two high and three low cycles keep the pin well below half the system clock
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk) pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule // pin_source
`default_nettype wire

// ---- tb/auto_reload_timer_four_bench.sv ----
// Register-level tests of the auto-reload timer four
`timescale 1ns/100ps
`default_nettype none
module auto_reload_timer_four_bench;
  logic sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, pin_d = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic timer_io_pin_in, timer_io_pin_out, timer_io_pin_oe, timer_irq, serial_port_one_baud_tick;
  logic [15:0] cyc = 16'h0000, tp, tp_prev, tk, tk_prev, v;
  logic [15:0] dv [4] = '{16'h0001, 16'h0008, 16'h0040, 16'h0100};
  int n_fail = 0, n_checks = 0, i;
  always #50 sys_clk = ~sys_clk;
  auto_reload_timer_four dut_u (.*);
  pin_source pin_u (.sys_clk(sys_clk), .pin(timer_io_pin_in));
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task rc(output logic [15:0] c);
    rd(3'h1, c[15:8]);
    rd(3'h2, c[7:0]);
  endtask
  // Stops the timer first: a count write while running changes only the reload
  task ld(input logic [15:0] c);
    wr(3'h0, 8'h00);
    wr(3'h1, c[15:8]);
    wr(3'h2, c[7:0]);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 16'h0001;
    pin_d <= timer_io_pin_out;
    if (timer_io_pin_out !== pin_d) begin
      tp_prev <= tp;
      tp <= cyc;
    end
    if (serial_port_one_baud_tick === 1'b1) begin
      tk_prev <= tk;
      tk <= cyc;
    end
    if (cyc === 16'h4e20) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], v[7:0]);
      chk(v[7:0], 8'h00);
    end
    ld(16'habcd);
    rc(v);
    chk(v, 16'habcd);
    ld(16'hfff0);
    wr(3'h3, 8'h01);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h12);
    wr(3'h2, 8'h34);
    for (i = 0; i < 40 && timer_irq !== 1'b1; i++) @(posedge sys_clk) #1;
    chk(timer_irq, 1'b1);
    wr(3'h0, 8'h80);
    rc(v);
    chk(v[15:8], 8'h12);
    wr(3'h3, 8'h00);
    chk(timer_irq, 1'b0);
    wr(3'h3, 8'h01);
    chk(timer_irq, 1'b1);
    wr(3'h0, 8'h00);
    chk(timer_irq, 1'b0);
    for (i = 0; i < 4; i++) begin
      ld(16'hfffe);
      wr(3'h0, {2'b01, i[1:0], 4'h2});
      repeat (8 * dv[i]) @(posedge sys_clk);
      #1 chk(tp - tp_prev, dv[i] << 1);
      chk(timer_io_pin_oe, 1'b1);
    end
    ld(16'hfffe);
    wr(3'h0, 8'h46);
    repeat (200) @(posedge sys_clk);
    #1 chk(tk - tk_prev, 16'h0020);
    chk(tp - tp_prev, 16'h0020);
    chk(timer_irq, 1'b1);
    for (i = 0; i < 4; i++) begin
      ld(16'hfff8);
      wr(3'h0, {1'b0, i[1], 3'b001, i[0], 2'b11});
      repeat (20) @(posedge sys_clk);
      rc(v);
      chk(v, 16'hfff8);
      pin_u.pulses(4);
      repeat (2) @(posedge sys_clk);
      #1 chk(timer_irq, !i[1]);
      repeat (16) @(posedge sys_clk);
      #1 chk(timer_irq, 1'b1);
    end
    ld(16'hfffe);
    wr(3'h0, 8'h03);
    pin_u.pulses(1);
    repeat (8) @(posedge sys_clk);
    #1 chk(timer_irq, 1'b0);
    pin_u.pulses(1);
    repeat (6) @(posedge sys_clk);
    #1 chk(timer_irq, 1'b1);
    tally_and_finish;
  end
endmodule // auto_reload_timer_four_bench
`default_nettype wire
